// ===== fbc_defs.svh
// timing and field constants for the flash bus controller
`ifndef FBC_DEFS_SVH
`define FBC_DEFS_SVH
`define FBC_CLK_PERIOD_NS 10
`define FBC_ADDR_W 22
`define FBC_DATA_W 8
`define FBC_SECTOR_LSB 16
`define FBC_ACCESS_NS 90
`define FBC_ACCESS_CYC ((`FBC_ACCESS_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)
`define FBC_WRITE_NS 50
`define FBC_WRITE_CYC ((`FBC_WRITE_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)
`define FBC_RESET_PULSE_NS 500
`define FBC_RESET_PULSE_CYC ((`FBC_RESET_PULSE_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)
`define FBC_RESET_HIGH_NS 50
`define FBC_RESET_HIGH_CYC ((`FBC_RESET_HIGH_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)
`endif

// ===== fbc_pkg.sv
// types for the flash bus controller
package fbc_pkg;
  typedef enum logic [1:0] {
    fbc_op_read,
    fbc_op_write,
    fbc_op_reset
  } fbc_op_type;

  typedef struct packed {
    fbc_op_type op;
    logic [21:0] addr;
    logic [7:0] data;
  } fbc_req_type;

  typedef struct packed {
    logic chip_sel_n;
    logic out_en_n;
    logic wr_en_n;
    logic reset_n;
  } fbc_ctl_type;
endpackage

// ===== fbc_host.sv
// host-side bus controller driving a byte-wide parallel flash
// Overview of operation
// R1: reads drive select and output enable low, write enable and reset high.
// R2: device gates data by output enable; host floats its drive while reading.
// R3: writes drive select and write enable low with output enable high.
// R4: device latches commands internally; host just issues write cycles.
// R5: device starts in read-array mode after power-up or hardware reset.
// R6: device stays in read-array mode until a write alters the command.
// R7: bad or out-of-order writes return the device to read-array mode.
// R8: erase covers one, several or all sectors by sector address bits.
// R9: after identification sequence, reads return identification codes.
// R10: during program or erase, reads return status bits.
// R11: erase-resume only accepted while erase is suspended.
// R12: select and reset high puts device in standby with floated outputs.
// R13: first read after standby waits the full select access time.
// R14: reset low also places the device in standby.
// R15: deselecting during program or erase lets the operation finish.
// R16: reset held for minimum pulse aborts, floats outputs, ignores cycles.
// R17: reset during embedded operation keeps ready/busy low until done.
// R18: reset without embedded operation completes within shorter ready time.
// R19: host waits reset-high recovery time before the next read.
// R20: host should re-issue a program or erase that reset interrupted; this controller only flags it on o_interrupted.
// R21: reset input is active low.
// R22: sectors are uniform; sector chosen by upper address bits.
// R23: ready/busy high when idle, low while embedded work runs.
// R24: busy-time writes do not disturb the embedded operation.
`include "fbc_defs.svh"

module fbc_host
  import fbc_pkg::*;
#(
  parameter int ACCESS_CYC = `FBC_ACCESS_CYC,
  parameter int WRITE_CYC = `FBC_WRITE_CYC,
  parameter int RESET_PULSE_CYC = `FBC_RESET_PULSE_CYC,
  parameter int RESET_HIGH_CYC = `FBC_RESET_HIGH_CYC
)
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_req_valid,
  input wire fbc_req_type i_req,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_data,
  output logic o_interrupted,
  output logic o_dev_ready,
  output logic [21:0] o_address_pins,
  output fbc_ctl_type o_ctl,
  output logic [7:0] o_data_pins,
  output logic o_data_pins_oe_n,
  input wire logic [7:0] i_data_pins,
  input wire logic i_ready_busy_n
);

  typedef enum logic [2:0] {
    st_idle,
    st_read,
    st_write,
    st_rst_pulse,
    st_rst_wait,
    st_gap
  } fbc_state_type;

  localparam int CNT_W = 16;

  fbc_state_type state;
  logic [CNT_W-1:0] cnt;
  logic [7:0] data_sync1;
  logic [7:0] data_sync;
  logic rb_sync1;
  logic rb_sync;
  logic busy_at_reset;

  // pins are asynchronous to our clock
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      data_sync1 <= 8'h00;
      data_sync <= 8'h00;
      rb_sync1 <= 1'b1;
      rb_sync <= 1'b1;
    end
    else
    begin
      data_sync1 <= i_data_pins;
      data_sync <= data_sync1;
      rb_sync1 <= i_ready_busy_n;
      rb_sync <= rb_sync1;
    end
  end

  assign o_req_ready = (state == st_idle);
  assign o_dev_ready = rb_sync; // [R23]

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state <= st_idle;
      cnt <= '0;
      busy_at_reset <= 1'b0;
    end
    else
    begin
      case (state)
        st_idle:
        begin
          cnt <= '0;
          if (i_req_valid)
          begin
            case (i_req.op)
              fbc_op_read: state <= st_read;
              fbc_op_write: state <= st_write;
              fbc_op_reset:
              begin
                state <= st_rst_pulse;
                busy_at_reset <= !rb_sync; // [R17]
              end
              default: state <= st_idle;
            endcase
          end
        end
        st_read:
        begin
          // select rises after each cycle, so every read pays the full access time
          cnt <= cnt + 1'b1; // [R13]
          if (cnt == CNT_W'(ACCESS_CYC + 2))
          begin
            state <= st_gap;
            cnt <= '0;
          end
        end
        st_write:
        begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(WRITE_CYC))
          begin
            state <= st_gap;
            cnt <= '0;
          end
        end
        st_rst_pulse:
        begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(RESET_PULSE_CYC - 1)) // [R16]
          begin
            state <= st_rst_wait;
            cnt <= '0;
          end
        end
        st_rst_wait:
        begin
          // recovery time, then ready/busy must be high again
          if (cnt < CNT_W'(RESET_HIGH_CYC))
            cnt <= cnt + 1'b1; // [R19]
          else if (rb_sync)
            state <= st_idle; // [R17] [R18]
        end
        st_gap:
        begin
          state <= st_idle;
        end
        default: state <= st_idle;
      endcase
    end
  end

  // bus pin levels per state
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_ctl <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, wr_en_n: 1'b1, reset_n: 1'b1};
      o_address_pins <= '0;
      o_data_pins <= 8'h00;
      o_data_pins_oe_n <= 1'b1;
    end
    else
    begin
      o_ctl <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, wr_en_n: 1'b1, reset_n: 1'b1}; // [R12]
      o_data_pins_oe_n <= 1'b1; // [R2]
      if (state == st_idle && i_req_valid)
      begin
        o_address_pins <= i_req.addr; // [R22] [R8]
        o_data_pins <= i_req.data;
        if (i_req.op == fbc_op_read)
          o_ctl <= '{chip_sel_n: 1'b0, out_en_n: 1'b0, wr_en_n: 1'b1, reset_n: 1'b1}; // [R1]
        else if (i_req.op == fbc_op_write)
        begin
          o_ctl <= '{chip_sel_n: 1'b0, out_en_n: 1'b1, wr_en_n: 1'b0, reset_n: 1'b1}; // [R3]
          o_data_pins_oe_n <= 1'b0;
        end
        else
          o_ctl.reset_n <= 1'b0; // [R21] [R14]
      end
      else if (state == st_read && cnt != CNT_W'(ACCESS_CYC + 2))
        o_ctl <= '{chip_sel_n: 1'b0, out_en_n: 1'b0, wr_en_n: 1'b1, reset_n: 1'b1};
      else if (state == st_write && cnt != CNT_W'(WRITE_CYC))
      begin
        // data held one cycle past write enable rise for hold time
        o_ctl <= '{chip_sel_n: 1'b0, out_en_n: 1'b1, wr_en_n: 1'b0, reset_n: 1'b1};
        o_data_pins_oe_n <= 1'b0;
      end
      else if (state == st_write)
        o_data_pins_oe_n <= 1'b0;
      else if (state == st_rst_pulse && cnt != CNT_W'(RESET_PULSE_CYC - 1))
        o_ctl.reset_n <= 1'b0; // [R16]
    end
  end

  // capture read data after synchroniser delay
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_rsp_valid <= 1'b0;
      o_rsp_data <= 8'h00;
    end
    else
    begin
      o_rsp_valid <= 1'b0;
      if (state == st_read && cnt == CNT_W'(ACCESS_CYC + 2))
      begin
        o_rsp_valid <= 1'b1; // [R9] [R10]
        o_rsp_data <= data_sync;
      end
    end
  end

  // flags that a reset cut an embedded operation short
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_interrupted <= 1'b0;
    else if (state == st_rst_wait && rb_sync && cnt >= CNT_W'(RESET_HIGH_CYC))
      o_interrupted <= busy_at_reset; // [R20]
  end

  rd_ctl_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_ctl.chip_sel_n && !o_ctl.out_en_n |-> o_ctl.wr_en_n && o_data_pins_oe_n) // [R1]
    else $error("read strobes overlap write");
  wr_ctl_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_ctl.wr_en_n |-> !o_ctl.chip_sel_n && o_ctl.out_en_n && !o_data_pins_oe_n) // [R3]
    else $error("write strobe without select or data");
  rst_idle_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_ctl.reset_n |-> o_ctl.chip_sel_n && o_ctl.wr_en_n && o_ctl.out_en_n) // [R16]
    else $error("cycle issued during reset pulse");
  rst_width_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(o_ctl.reset_n) |-> !o_ctl.reset_n [*2]) // [R16]
    else $error("reset pulse too short");
  rd_len_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(o_ctl.out_en_n) |-> !o_ctl.out_en_n [*3]) // [R13]
    else $error("read strobe too short");
  rsp_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_rsp_valid |-> $past(state) == st_read) // [R10]
    else $error("response outside a read");
  rec_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_ctl.reset_n) |-> o_ctl.out_en_n [*2]) // [R19]
    else $error("read too soon after reset");
  ready_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state == st_idle && $past(state) == st_rst_wait |-> $past(rb_sync)) // [R17]
    else $error("left reset wait while busy");
  cv_read_c: cover property (@(posedge i_clk) disable iff (!i_nrst) o_rsp_valid);
  cv_write_c: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(o_ctl.wr_en_n));
  cv_rst_c: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(o_ctl.reset_n));
  cv_intr_c: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(o_interrupted));

endmodule

// ===== fbc_flash_model.sv
// behavioural byte-wide flash device seen by the host controller
module fbc_flash_model
  import fbc_pkg::*;
#(
  parameter int PROG_CYC = 30,
  parameter int RST_CYC = 6,
  parameter int ERASE_CYC = 60,
  parameter int ACC_CYC = 2,
  // command offset, opcodes and code are arbitrary values of this model
  parameter logic [15:0] CMD_OFS = 16'h6d3b,
  parameter logic [7:0] CMD_ID = 8'h4e,
  parameter logic [7:0] CMD_ERASE = 8'hb1,
  parameter logic [7:0] CMD_SUSPEND = 8'h72,
  parameter logic [7:0] CMD_RESUME = 8'h8d,
  parameter logic [7:0] ID_CODE = 8'hc6
)
(
  input wire logic i_clk,
  input wire logic [21:0] i_address_pins,
  input wire fbc_ctl_type i_ctl,
  input wire logic [7:0] i_data_pins,
  output logic [7:0] o_data_pins,
  output logic o_ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  logic [7:0] pdata = 8'h00;
  logic [7:0] lat_data = 8'h00;
  logic [21:0] lat_addr = 22'h000000;
  logic wr_low = 1'b0;
  logic id_mode = 1'b0;
  logic erasing = 1'b0;
  logic suspended = 1'b0;
  logic esec = 1'b0;
  logic drive;
  logic valid;
  logic wr_done;
  logic cmd;
  int busy = 0;
  int held = 0;
  int sel_cnt = 0;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = i[7:0] ^ 8'h5a;
  end
  assign drive = !i_ctl.chip_sel_n && !i_ctl.out_en_n && i_ctl.reset_n;
  // data is garbage until select has been low for the access time
  assign valid = drive && sel_cnt >= ACC_CYC;
  assign wr_done = wr_low && i_ctl.wr_en_n;
  assign cmd = (lat_addr[15:0] == CMD_OFS);
  // released bus shows the inverse of the last byte, not a stale copy
  // only sector bit 16 is kept, so sectors alias in two groups
  assign o_data_pins = !valid ? ~last :
    busy > 0 ? {~pdata[7], 7'h00} :
    id_mode ? ID_CODE : mem[{i_address_pins[16], i_address_pins[6:0]}];
  assign o_ready_busy_n = (busy == 0);
  always @(posedge i_clk)
  begin
    if (valid)
      last <= o_data_pins;
    sel_cnt <= (!i_ctl.chip_sel_n && i_ctl.reset_n) ? sel_cnt + 1 : 0;
    wr_low <= !i_ctl.wr_en_n && !i_ctl.chip_sel_n && i_ctl.reset_n;
    if (wr_low)
    begin
      lat_addr <= i_address_pins;
      lat_data <= i_data_pins;
    end
    if (!i_ctl.reset_n)
    begin
      busy <= (busy > 0) ? RST_CYC : 0;
      id_mode <= 1'b0;
      erasing <= 1'b0;
      suspended <= 1'b0;
    end
    else if (wr_done && id_mode)
      id_mode <= 1'b0;
    else if (wr_done && busy > 0 && erasing && cmd && lat_data == CMD_SUSPEND)
    begin
      held <= busy;
      busy <= 0;
      suspended <= 1'b1;
    end
    else if (wr_done && busy == 0 && cmd)
    begin
      // unknown opcodes at the command offset are dropped
      if (lat_data == CMD_ID)
        id_mode <= 1'b1;
      else if (lat_data == CMD_RESUME && suspended)
      begin
        busy <= held;
        suspended <= 1'b0;
      end
      else if (lat_data == CMD_ERASE && !suspended)
      begin
        esec <= lat_addr[16];
        erasing <= 1'b1;
        pdata <= 8'hff;
        busy <= ERASE_CYC;
      end
    end
    else if (wr_done && busy == 0)
    begin
      mem[{lat_addr[16], lat_addr[6:0]}] <= lat_data;
      pdata <= lat_data;
      busy <= PROG_CYC;
    end
    else if (busy > 0)
    begin
      busy <= busy - 1;
      if (busy == 1 && erasing && !suspended)
      begin
        erasing <= 1'b0;
        for (int i = 0; i < 256; i++)
          if (i[7] == esec)
            mem[i] <= 8'hff;
      end
    end
  end
endmodule

// ===== tb_flash_bus_operation_control.sv
// self-checking bench for the flash bus controller
module tb_flash_bus_operation_control import fbc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic req_valid = 1'b0;
  fbc_req_type req = '0;
  logic ready, rsp_valid, interrupted, dev_ready, data_oe_n, rb_n;
  logic [7:0] rsp_data, host_dq, dev_dq, dq_bus;
  logic [21:0] addr, a;
  logic [7:0] d;
  fbc_ctl_type ctl;
  logic [7:0] shadow [256];
  logic [31:0] seed = 32'h90c0;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  // command offset, opcodes and code are arbitrary values of the device model
  localparam logic [15:0] CMD_OFS = 16'h6d3b;
  localparam logic [7:0] CMD_ID = 8'h4e;
  localparam logic [7:0] CMD_ERASE = 8'hb1;
  localparam logic [7:0] CMD_SUSPEND = 8'h72;
  localparam logic [7:0] CMD_RESUME = 8'h8d;
  localparam logic [7:0] ID_CODE = 8'hc6;
  assign dq_bus = data_oe_n ? dev_dq : host_dq;
  fbc_host #(.ACCESS_CYC(2), .WRITE_CYC(2), .RESET_PULSE_CYC(2), .RESET_HIGH_CYC(2)) i_fbc_host (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_req_valid(req_valid), .i_req(req),
    .o_req_ready(ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .o_interrupted(interrupted), .o_dev_ready(dev_ready), .o_address_pins(addr),
    .o_ctl(ctl), .o_data_pins(host_dq), .o_data_pins_oe_n(data_oe_n),
    .i_data_pins(dq_bus), .i_ready_busy_n(rb_n));
  fbc_flash_model #(.ACC_CYC(2), .CMD_OFS(CMD_OFS), .CMD_ID(CMD_ID), .CMD_ERASE(CMD_ERASE),
    .CMD_SUSPEND(CMD_SUSPEND), .CMD_RESUME(CMD_RESUME), .ID_CODE(ID_CODE)) i_fbc_flash_model (
    .i_clk(i_clk), .i_address_pins(addr), .i_ctl(ctl),
    .i_data_pins(dq_bus), .o_data_pins(dev_dq), .o_ready_busy_n(rb_n));
  always #5 i_clk = ~i_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // model keeps sector bit 16 and the low seven address bits
  function automatic logic [7:0] ix(input logic [21:0] ad);
    return {ad[16], ad[6:0]};
  endfunction
  // random data writes must not land on the command offset
  function automatic logic [21:0] wr_addr(input logic [31:0] s);
    logic [21:0] r;
    r = s[21:0];
    if (r[15:0] == CMD_OFS)
      r[15] = ~r[15];
    return r;
  endfunction
  task automatic final_report;
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask
  // called at a falling edge; ready is settled there, so the next rise takes it
  task automatic issue(input fbc_op_type op, input logic [21:0] ad, input logic [7:0] dt);
    while (ready !== 1'b1)
      @(negedge i_clk);
    req_valid = 1'b1;
    req = '{op, ad, dt};
    @(negedge i_clk);
    req_valid = 1'b0;
  endtask
  task automatic read_chk(input logic [21:0] ad, input logic [7:0] e);
    int n;
    n = 0;
    issue(fbc_op_read, ad, 8'h00);
    while (rsp_valid !== 1'b1 && n < 60)
    begin
      @(negedge i_clk);
      n++;
    end
    chk_bit("read response", 1'b1, rsp_valid);
    chk_byte("read data", e, rsp_data);
  endtask
  always @(negedge i_clk)
  begin
    if (i_nrst && !ctl.wr_en_n)
      chk_bit("write strobes", 1'b1, ctl.out_en_n & ~data_oe_n & ~ctl.chip_sel_n);
    if (i_nrst && !ctl.out_en_n)
      chk_bit("read strobes", 1'b1, data_oe_n & ctl.wr_en_n & ctl.reset_n);
  end
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      final_report;
    end
  end
  initial
  begin
    for (int i = 0; i < 256; i++)
      shadow[i] = i[7:0] ^ 8'h5a;
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    i_nrst = 1'b1;
    @(negedge i_clk);
    repeat (6)
    begin
      seed = xs(seed);
      read_chk(seed[21:0], shadow[ix(seed[21:0])]);
    end
    read_chk(22'h3fffff, shadow[8'hff]);
    repeat (3)
    begin
      seed = xs(seed);
      a = wr_addr(seed);
      d = seed[29:22];
      issue(fbc_op_write, a, d);
      read_chk(a, {~d[7], 7'h00});
      chk_bit("ready while busy", 1'b0, dev_ready);
      issue(fbc_op_write, a ^ 22'h1, ~d);
      while (dev_ready !== 1'b1)
        @(negedge i_clk);
      shadow[ix(a)] = d;
      read_chk(a, d);
      read_chk(a ^ 22'h1, shadow[ix(a ^ 22'h1)]);
    end
    // identification mode, then a stray write drops back to the array
    issue(fbc_op_write, {6'h00, CMD_OFS}, CMD_ID);
    read_chk(22'h000123, ID_CODE);
    issue(fbc_op_write, 22'h000007, 8'h33);
    read_chk(22'h000007, shadow[ix(22'h000007)]);
    chk_bit("ready after stray write", 1'b1, dev_ready);
    issue(fbc_op_write, {6'h00, CMD_OFS}, CMD_RESUME);
    read_chk(22'h000007, shadow[ix(22'h000007)]);
    chk_bit("ready after stray resume", 1'b1, dev_ready);
    // sector erase, suspended as soon as busy shows, then resumed
    issue(fbc_op_write, {6'h01, CMD_OFS}, CMD_ERASE);
    while (dev_ready !== 1'b0)
      @(negedge i_clk);
    issue(fbc_op_write, {6'h00, CMD_OFS}, CMD_SUSPEND);
    while (dev_ready !== 1'b1)
      @(negedge i_clk);
    read_chk(22'h010005, shadow[ix(22'h010005)]);
    issue(fbc_op_write, {6'h00, CMD_OFS}, CMD_RESUME);
    while (dev_ready !== 1'b0)
      @(negedge i_clk);
    while (dev_ready !== 1'b1)
      @(negedge i_clk);
    for (int i = 0; i < 128; i++)
      shadow[{1'b1, i[6:0]}] = 8'hff;
    read_chk(22'h010005, 8'hff);
    read_chk(22'h020005, shadow[ix(22'h020005)]);
    seed = xs(seed);
    a = wr_addr(seed);
    issue(fbc_op_write, a, a[7:0]);
    shadow[ix(a)] = a[7:0];
    // host sees busy two clocks late, so reset only once it shows
    while (dev_ready !== 1'b0)
      @(negedge i_clk);
    issue(fbc_op_reset, 22'h0, 8'h00);
    read_chk(a ^ 22'h2, shadow[ix(a ^ 22'h2)]);
    chk_bit("interrupted flag", 1'b1, interrupted);
    issue(fbc_op_reset, 22'h0, 8'h00);
    read_chk(a ^ 22'h4, shadow[ix(a ^ 22'h4)]);
    chk_bit("interrupted flag", 1'b0, interrupted);
    chk_bit("idle standby", 1'b1, ctl.chip_sel_n & ctl.reset_n & data_oe_n);
    final_report;
  end
endmodule
